/* sewrp_pkg.sv */
// constants, types and helper functions of the serial eeprom command engine
// What this block does
// - status write refused unless the arm latch was set beforehand
// - status write is opcode plus one byte; deselect starts timed cycle
// - status write keeps bits 7,3,2; bits 6..4 always read zero
// - select must rise right after the last data bit, else write dropped
// - busy flag reads 1 during the cycle, then 0; arm latch then cleared
// - new lock and protect bits apply only after the timed cycle ends
// - with lock bit 0, armed status writes pass whatever the protect pin
// - with lock bit 1 and protect pin high, armed status writes pass
// - lock bit 1 and protect pin low: every status write is refused
// - hardware lock follows the later of lock bit set or pin low
// - protected regions refuse array writes, others accept them
// - array read: opcode, two address bytes, then the addressed byte out
// - read pointer steps after every byte while selected
// - read pointer wraps from the top address to zero
// - deselect ends a read at once, at any bit
// - array read refused while a timed cycle runs
// - address bit 15 is ignored
// - array write: opcode, address, data; aligned deselect starts cycle
// - further bytes advance the in-page column; all program together
// - 64-byte page; overflow wraps to page start and overwrites
// - array write refused: unarmed, busy, misaligned or protected page
// - each 4-byte word carries 6 check bits; single errors corrected
// - opcodes 01 status write, 03 read, 02 write; unknown waits for deselect
// - protect codes: none, from 6000h, from 4000h, whole array
// - msb first; input sampled on clock rise, output moved on fall
package sewrp_pkg;

	//------------------------------------------------------------
	// command codes
	//------------------------------------------------------------
	localparam logic [7:0] OPC_STORE  = 8'h01;
	localparam logic [7:0] OPC_WRITE  = 8'h02;
	localparam logic [7:0] OPC_READ   = 8'h03;
	localparam logic [7:0] OPC_DISARM = 8'h04;
	localparam logic [7:0] OPC_RDSR   = 8'h05;
	localparam logic [7:0] OPC_ARM    = 8'h06;

	//------------------------------------------------------------
	// status byte layout
	//------------------------------------------------------------
	localparam int SR_LOCK  = 7;
	localparam int SR_BP_HI = 3;
	localparam int SR_BP_LO = 2;
	localparam int SR_ARM   = 1;
	localparam int SR_BUSY  = 0;
	localparam int SR_Z_HI  = 6;
	localparam int SR_Z_LO  = 4;

	//------------------------------------------------------------
	// array geometry and protection
	//------------------------------------------------------------
	localparam int ADDR_W     = 15;
	localparam int PAGE_BYTES = 64;
	localparam int PAGE_W     = 6;
	localparam int WORD_BYTES = 4;
	localparam int WORD_W     = 32;
	localparam int ECC_W      = 6;
	localparam int CODE_W     = 38;
	localparam logic [ADDR_W-1:0] PROT_QTR  = 15'h6000;
	localparam logic [ADDR_W-1:0] PROT_HALF = 15'h4000;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QTR  = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffff_ffff;
	localparam logic [2:0] BIT_LAST = 3'h7;

	//------------------------------------------------------------
	// timing and buffering
	//------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 8;
	localparam int STATUS_CYCLE_NS = 5000000;
	localparam int ARRAY_CYCLE_NS  = 5000000;
	localparam int TMR_W           = 24;
	localparam int WFIFO_DEPTH     = 16;

	typedef enum {S_IDLE, S_OPC, S_ADDR, S_RD, S_STAT, S_SRDATA, S_WDATA,
		S_WAIT} sewrp_spi_t;
	typedef enum {E_IDLE, E_DRAIN, E_SRT, E_ART} sewrp_eng_t;

	// one write byte on its way to the page buffer
	typedef struct packed {
		logic [7:0]        data;
		logic [PAGE_W-1:0] col;
	} sewrp_wbyte_t;

	// hamming check bits: data sits on non-power-of-two code positions
	function automatic logic [ECC_W-1:0] sewrp_ecc(input logic [WORD_W-1:0] d);
		logic [ECC_W-1:0] c;
		int j;
		c = '0;
		j = 0;
		for (int p = 1; p <= CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[j]) c = c ^ p[ECC_W-1:0];
				j++;
			end
		end
		return c;
	endfunction

	// single error repair; a syndrome on a check position leaves data alone
	function automatic logic [WORD_W-1:0] sewrp_fix(input logic [WORD_W-1:0] d,
		input logic [ECC_W-1:0] c);
		logic [ECC_W-1:0] s;
		logic [WORD_W-1:0] r;
		int j;
		s = sewrp_ecc(d) ^ c;
		r = d;
		j = 0;
		for (int p = 1; p <= CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (s == p[ECC_W-1:0]) r[j] = ~d[j];
				j++;
			end
		end
		return r;
	endfunction

	// region guarded by the block protect code
	function automatic logic sewrp_prot(input logic [1:0] bp,
		input logic [ADDR_W-1:0] a);
		case (bp)
			BP_NONE: return 1'b0;
			BP_QTR:  return a >= PROT_QTR;
			BP_HALF: return a >= PROT_HALF;
			default: return 1'b1;
		endcase
	endfunction

endpackage

/* sewrp_top.sv */
// serial eeprom command engine with its write-byte fifo
`timescale 1ns/1ps

//------------------------------------------------------------
// write-byte fifo
//------------------------------------------------------------
module sewrp_fifo #(
	parameter int W     = 14,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wp, rp;
	logic [PW:0]   cnt;
	logic          do_in, do_out;

	assign do_in     = in_valid & in_ready;
	assign do_out    = out_valid & out_ready;
	assign in_ready  = cnt != (PW+1)'(DEPTH);
	assign out_valid = cnt != '0;
	assign out_data  = mem[rp];

	// pointers wrap by depth so it need not be a power of two
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (do_in) begin
				mem[wp] <= in_data;
				wp      <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
			end
			if (do_out) rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
			if (do_in && !do_out) cnt <= cnt + 1'b1;
			else if (do_out && !do_in) cnt <= cnt - 1'b1;
		end
	end
endmodule // sewrp_fifo

//------------------------------------------------------------
// top: serial slave, protection, page buffer, timed cycles
//------------------------------------------------------------
module sewrp_top import sewrp_pkg::*; #(
	parameter int T_STATUS_NS = STATUS_CYCLE_NS,
	parameter int T_ARRAY_NS  = ARRAY_CYCLE_NS,
	parameter int FIFO_DEPTH  = WFIFO_DEPTH
) (
	input  wire logic REF_CLK,
	input  wire logic NRST,
	input  wire logic SCK,
	input  wire logic CS_N,
	input  wire logic SI,
	input  wire logic WP_N,
	output logic      SO,
	output logic      SO_OE_N,
	output logic [7:0] STATUS,
	output logic      HW_LOCK
);
	localparam int SR_CYC = (T_STATUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AR_CYC = (T_ARRAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NWORDS = (1 << ADDR_W) / WORD_BYTES;
	localparam int WIDX_W = ADDR_W - 2;
	localparam int PG_W   = ADDR_W - PAGE_W;
	localparam int WPP    = PAGE_BYTES / WORD_BYTES;
	localparam int WPP_W  = PAGE_W - 2;
	localparam logic [CODE_W-1:0] ERASED_CODE =
		{sewrp_ecc(ERASED_WORD), ERASED_WORD};

	typedef struct packed {
		logic [2:0]              sck_s, cs_s, si_s, wp_s;
		logic                    sck_f, cs_f, wp_f;
		sewrp_spi_t              st;
		logic [2:0]              bitc, ocnt;
		logic [7:0]              sh, opc, obuf;
		logic [ADDR_W-1:0]       addr;
		logic                    so, so_oe_n, aligned, got_byte;
		logic                    wr_ok, commit, armed, lock, busy, hwl;
		logic [1:0]              bp;
		logic [2:0]              pend;
		sewrp_eng_t              eng;
		logic [TMR_W-1:0]        tmr;
		logic [PG_W-1:0]         page;
		logic [PAGE_BYTES-1:0]   pflag;
		logic [PAGE_BYTES*8-1:0] pdata;
		logic                    push;
		sewrp_wbyte_t            pushd;
		logic [7:0]              status_o;
	} sewrp_state_t;

	sewrp_state_t      q, next_q;
	logic [CODE_W-1:0] mem [NWORDS];
	logic              sck_rise, sck_fall, cs_rise, cs_fall, si;
	logic              rx_go, byte_done, opc_done, addr_done, rd_step;
	logic              hw_lock, mem_we, pop, f_in_ready, f_out_valid;
	logic [7:0]        in_byte, sr, rd_byte;
	logic [ADDR_W-1:0] naddr, rd_addr;
	logic [WORD_W-1:0] rd_word;
	sewrp_wbyte_t      f_out;

	//------------------------------------------------------------
	// pin edges: a change counts once stages two and three agree
	//------------------------------------------------------------
	assign sck_rise = (q.sck_s[1] == q.sck_s[2]) & q.sck_s[2] & ~q.sck_f;
	assign sck_fall = (q.sck_s[1] == q.sck_s[2]) & ~q.sck_s[2] & q.sck_f;
	assign cs_rise  = (q.cs_s[1] == q.cs_s[2]) & q.cs_s[2] & ~q.cs_f;
	assign cs_fall  = (q.cs_s[1] == q.cs_s[2]) & ~q.cs_s[2] & q.cs_f;
	assign si       = q.si_s[2];
	assign in_byte  = {q.sh[6:0], si};
	assign naddr    = {q.addr[ADDR_W-2:0], si};
	assign hw_lock  = q.lock & ~q.wp_f;
	assign sr = {q.lock, 3'h0, q.bp, q.armed, q.busy};

	// bit and byte events of the current frame
	assign rx_go     = !cs_rise && !cs_fall && !q.cs_f && sck_rise
		&& q.st != S_IDLE;
	assign byte_done = rx_go && q.bitc == BIT_LAST;
	assign opc_done  = byte_done && q.st == S_OPC;
	assign addr_done = byte_done && q.st == S_ADDR && q.got_byte;
	assign rd_step   = !cs_rise && !cs_fall && !q.cs_f && sck_fall
		&& q.st == S_RD && q.ocnt == BIT_LAST;

	//------------------------------------------------------------
	// array read path with single-error repair
	//------------------------------------------------------------
	always_comb begin
		rd_addr = (q.st == S_ADDR) ? naddr : q.addr + 1'b1;
	end
	assign rd_word = sewrp_fix(mem[rd_addr[ADDR_W-1:2]][WORD_W-1:0],
		mem[rd_addr[ADDR_W-1:2]][CODE_W-1:WORD_W]);
	assign rd_byte = rd_word[rd_addr[1:0]*8 +: 8];

	sewrp_fifo #(
		.W     ($bits(sewrp_wbyte_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wfifo (
		.clk       (REF_CLK),
		.nrst      (NRST),
		.in_valid  (q.push),
		.in_ready  (f_in_ready),
		.in_data   (q.pushd),
		.out_valid (f_out_valid),
		.out_ready (pop),
		.out_data  (f_out)
	);

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb begin
		next_q      = q;
		next_q.push = 1'b0;
		mem_we      = 1'b0;
		next_q.sck_s = {q.sck_s[1:0], SCK};
		next_q.cs_s  = {q.cs_s[1:0], CS_N};
		next_q.si_s  = {q.si_s[1:0], SI};
		next_q.wp_s  = {q.wp_s[1:0], WP_N};
		if (q.sck_s[1] == q.sck_s[2]) next_q.sck_f = q.sck_s[2];
		if (q.cs_s[1] == q.cs_s[2]) next_q.cs_f = q.cs_s[2];
		if (q.wp_s[1] == q.wp_s[2]) next_q.wp_f = q.wp_s[2];
		next_q.hwl      = hw_lock;
		next_q.status_o = sr;
		// a byte the fifo could not take spoils the whole page write
		if (q.push && !f_in_ready) next_q.wr_ok = 1'b0;

		// page buffer fill; stalls while the page is being programmed
		pop = f_out_valid && q.eng != E_ART;
		if (pop) begin
			next_q.pdata[f_out.col*8 +: 8] = f_out.data;
			next_q.pflag[f_out.col]        = 1'b1;
		end

		// timed cycles; lock and protect bits move only at the end
		case (q.eng)
			E_DRAIN: begin
				if (!f_out_valid) begin
					if (q.commit && q.wr_ok && q.pflag != '0) begin
						next_q.eng = E_ART;
						next_q.tmr = TMR_W'(AR_CYC);
					end else begin
						next_q.eng   = E_IDLE;
						next_q.busy  = 1'b0;
						next_q.pflag = '0;
					end
				end
			end
			E_SRT: begin
				if (q.tmr <= TMR_W'(1)) begin
					next_q.lock  = q.pend[2];
					next_q.bp    = q.pend[1:0];
					next_q.armed = 1'b0;
					next_q.busy  = 1'b0;
					next_q.eng   = E_IDLE;
				end else next_q.tmr = q.tmr - 1'b1;
			end
			E_ART: begin
				if (q.tmr <= TMR_W'(1)) begin
					mem_we       = 1'b1;
					next_q.armed = 1'b0;
					next_q.busy  = 1'b0;
					next_q.pflag = '0;
					next_q.eng   = E_IDLE;
				end else next_q.tmr = q.tmr - 1'b1;
			end
			default: ;
		endcase

		// serial front end
		if (cs_rise) begin
			next_q.st      = S_IDLE;
			next_q.so_oe_n = 1'b1;
			case (q.st)
				S_SRDATA: begin
					if (q.aligned && q.got_byte) begin
						next_q.eng  = E_SRT;
						next_q.tmr  = TMR_W'(SR_CYC);
						next_q.busy = 1'b1;
					end
				end
				S_WDATA: begin
					next_q.eng    = E_DRAIN;
					next_q.busy   = 1'b1;
					next_q.commit = q.aligned && q.got_byte;
				end
				S_WAIT: begin
					if (q.aligned && q.opc == OPC_ARM) next_q.armed = 1'b1;
					else if (q.aligned && q.opc == OPC_DISARM)
						next_q.armed = 1'b0;
				end
				default: ;
			endcase
		end else if (cs_fall) begin
			next_q.st       = S_OPC;
			next_q.bitc     = '0;
			next_q.aligned  = 1'b0;
			next_q.got_byte = 1'b0;
			next_q.wr_ok    = 1'b1;
		end else if (rx_go) begin
			next_q.sh      = in_byte;
			next_q.bitc    = q.bitc + 3'h1;
			next_q.aligned = q.bitc == BIT_LAST;
			if (q.st == S_ADDR) next_q.addr = naddr;
			if (q.bitc == BIT_LAST) begin
				case (q.st)
					S_OPC: begin
						next_q.opc = in_byte;
						case (in_byte)
							OPC_RDSR: begin
								next_q.st   = S_STAT;
								next_q.obuf = sr;
								next_q.ocnt = '0;
							end
							OPC_STORE: next_q.st = (q.armed && !hw_lock && !q.busy)
								? S_SRDATA : S_WAIT;
							OPC_READ: next_q.st = q.busy ? S_WAIT : S_ADDR;
							OPC_WRITE: next_q.st = (q.armed && !q.busy)
								? S_ADDR : S_WAIT;
							default: next_q.st = S_WAIT;
						endcase
					end
					S_ADDR: begin
						next_q.got_byte = 1'b1;
						if (q.got_byte) begin
							next_q.got_byte = 1'b0;
							if (q.opc == OPC_READ) begin
								next_q.st   = S_RD;
								next_q.obuf = rd_byte;
								next_q.ocnt = '0;
							end else if (sewrp_prot(q.bp, naddr)) begin
								next_q.st = S_WAIT;
							end else begin
								next_q.st   = S_WDATA;
								next_q.page = naddr[ADDR_W-1:PAGE_W];
							end
						end
					end
					S_SRDATA: begin
						next_q.got_byte = 1'b1;
						next_q.pend = {in_byte[SR_LOCK], in_byte[SR_BP_HI],
							in_byte[SR_BP_LO]};
					end
					S_WDATA: begin
						next_q.got_byte   = 1'b1;
						next_q.push       = 1'b1;
						next_q.pushd.data = in_byte;
						next_q.pushd.col  = q.addr[PAGE_W-1:0];
						// column wraps inside the page
						next_q.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + 1'b1;
					end
					default: ;
				endcase
			end
		end else if (!q.cs_f && sck_fall && (q.st == S_RD || q.st == S_STAT)) begin
			next_q.so_oe_n = 1'b0;
			next_q.so      = q.obuf[7];
			next_q.obuf    = {q.obuf[6:0], 1'b0};
			next_q.ocnt    = q.ocnt + 3'h1;
			if (q.ocnt == BIT_LAST) begin
				if (q.st == S_RD) begin
					next_q.addr = rd_addr;
					next_q.obuf = rd_byte;
				end else next_q.obuf = sr;
			end
		end
	end

	// state register; select idles high so nothing starts at release
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			q         <= '0;
			q.cs_s    <= 3'h7;
			q.cs_f    <= 1'b1;
			q.so_oe_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	//------------------------------------------------------------
	// array: touched words are merged and re-encoded whole
	//------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge NRST) begin
		logic [WORD_W-1:0] w_new;
		if (!NRST) begin
			for (int i = 0; i < NWORDS; i++) mem[i] <= ERASED_CODE;
		end else if (mem_we) begin
			for (int w = 0; w < WPP; w++) begin
				if (|q.pflag[w*WORD_BYTES +: WORD_BYTES]) begin
					w_new = sewrp_fix(mem[{q.page, WPP_W'(w)}][WORD_W-1:0],
						mem[{q.page, WPP_W'(w)}][CODE_W-1:WORD_W]);
					for (int b = 0; b < WORD_BYTES; b++) begin
						if (q.pflag[w*WORD_BYTES + b])
							w_new[b*8 +: 8] = q.pdata[(w*WORD_BYTES + b)*8 +: 8];
					end
					mem[{q.page, WPP_W'(w)}] <= {sewrp_ecc(w_new), w_new};
				end
			end
		end
	end

	assign SO      = q.so;
	assign SO_OE_N = q.so_oe_n;
	assign STATUS  = q.status_o;
	assign HW_LOCK = q.hwl;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	a_sr_unarmed: assert property (opc_done && in_byte == OPC_STORE && !q.armed
		|=> q.st == S_WAIT) else $error("status write taken unarmed");
	a_sr_start: assert property (cs_rise && q.st == S_SRDATA && q.aligned
		&& q.got_byte |=> q.busy && q.eng == E_SRT)
		else $error("status cycle not started");
	a_zero_bits: assert property (STATUS[SR_Z_HI:SR_Z_LO] == 3'h0)
		else $error("status bits 6..4 not zero");
	a_late_cs: assert property (cs_rise && q.st == S_SRDATA && !q.aligned
		|=> !q.busy) else $error("misaligned status write ran");
	a_arm_clear: assert property ($fell(q.busy) && $past(q.eng) == E_SRT
		|-> !q.armed && q.eng == E_IDLE) else $error("arm left set");
	a_sr_hold: assert property (q.eng == E_SRT && q.tmr > TMR_W'(1)
		|=> $stable(q.lock) && $stable(q.bp))
		else $error("protect bits moved early");
	a_hw_lock: assert property (opc_done && in_byte == OPC_STORE && hw_lock
		|=> q.st == S_WAIT) else $error("locked status write taken");
	a_prot_wr: assert property (addr_done && q.opc == OPC_WRITE
		&& sewrp_prot(q.bp, naddr) |=> q.st == S_WAIT)
		else $error("protected page accepted");
	a_busy_rd: assert property (opc_done && in_byte == OPC_READ && q.busy
		|=> q.st == S_WAIT) else $error("read taken while busy");
	a_rd_wrap: assert property (rd_step && q.addr == '1 |=> q.addr == '0)
		else $error("read pointer did not wrap");
	a_cs_end: assert property (cs_rise |=> q.so_oe_n && q.st == S_IDLE)
		else $error("read not ended on deselect");

	c_sr_done: cover property (q.eng == E_SRT ##1 q.eng == E_IDLE);
	c_arr_done: cover property (q.eng == E_ART ##1 q.eng == E_IDLE);
	c_rd_wrap: cover property (rd_step && q.addr == '1);
	c_fifo_full: cover property (q.push && !f_in_ready);
endmodule // sewrp_top

/* sewrp_host.sv */
// serial host model that drives the eeprom link from the far side
`timescale 1ns/1ps

module sewrp_host (
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe_n,
	output logic      drv
);

	//----------------------------
	// mode 0 framing
	//----------------------------
	localparam realtime HALF = 62.5;
	logic               lq;

	// idle: deselected, clock low
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		lq = 1'b0;
		drv = 1'b0;
	end

	// select, then a whole period before the first rise
	task automatic sel();
		drv = 1'b0;
		#(HALF) cs_n = 1'b0;
		#(HALF);
	endtask

	// n bits msb first; released line reads as the inverse of the last bit
	task automatic xbits(input logic [7:0] d, input int n,
		output logic [7:0] q);
		q = '0;
		for (int i = 0; i < n; i++) begin
			si = d[7-i];
			#(HALF) sck = 1'b1;
			q = {q[6:0], so_oe_n ? ~lq : so};
			lq = q[0];
			if (!so_oe_n) drv = 1'b1;
			#(HALF) sck = 1'b0;
		end
	endtask

	// rise between the last rise and the next, then a quiet gap
	task automatic desel();
		#(HALF / 2) cs_n = 1'b1;
		si = ~si;
		#(HALF * 4);
	endtask

endmodule // sewrp_host

/* sewrp_top_test.sv */
// self-checking bench of the serial eeprom command engine
`timescale 1ns/1ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module sewrp_top_test import sewrp_pkg::*;;

	//----------------------------
	// nets and design
	//----------------------------
	logic       ref_clk, nrst, wp_n, sck, cs_n, si;
	logic       so, so_oe_n, hw_lock, drv;
	logic [7:0] status, q;
	int         err_count = 0;
	int         compares = 0;
	int         cyc = 0;

	// short timed cycles keep the run brief; the array cycle must still
	// outlast a refused read opcode sent right after the write
	sewrp_top #(.T_STATUS_NS(800), .T_ARRAY_NS(2400), .FIFO_DEPTH(16))
	u_sewrp_top (.REF_CLK(ref_clk), .NRST(nrst), .SCK(sck), .CS_N(cs_n),
		.SI(si), .WP_N(wp_n), .SO(so), .SO_OE_N(so_oe_n),
		.STATUS(status), .HW_LOCK(hw_lock));

	sewrp_host u_sewrp_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe_n(so_oe_n), .drv(drv));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// hang guard, about five times the expected run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 60000) begin
			err_count++;
			conclude();
		end
	end

	//----------------------------
	// access tasks
	//----------------------------
	task automatic conclude();
		$display("err_count %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// opcode with optional whole data byte
	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nd);
		u_sewrp_host.sel();
		u_sewrp_host.xbits(op, 8, q);
		if (nd > 0) u_sewrp_host.xbits(d, 8, q);
		u_sewrp_host.desel();
	endtask

	// opcode then address, high byte first
	task automatic hdr(input logic [7:0] op, input logic [15:0] a);
		u_sewrp_host.sel();
		u_sewrp_host.xbits(op, 8, q);
		u_sewrp_host.xbits(a[15:8], 8, q);
		u_sewrp_host.xbits(a[7:0], 8, q);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
		cmd(OPC_ARM, 8'h00, 0);
		hdr(OPC_WRITE, a);
		foreach (d[i]) u_sewrp_host.xbits(d[i], 8, q);
		u_sewrp_host.desel();
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e[$]);
		hdr(OPC_READ, a);
		foreach (e[i]) begin
			u_sewrp_host.xbits(8'h00, 8, q);
			`CHK(q, e[i])
		end
		u_sewrp_host.desel();
	endtask

	// host polls busy, bounded; the wait length is not fixed
	task automatic idle();
		int n = 0;
		while (status[0] !== 1'b0 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(status[0], 1'b0)
	endtask

	task automatic setwp(input logic v);
		@(posedge ref_clk);
		#1 wp_n = v;
		repeat (8) @(posedge ref_clk);
	endtask

	// a whole byte when na is 0, then one stray bit, so deselect misses the boundary
	task automatic odd(input logic [7:0] op, input int na);
		hdr(op, 16'h0100);
		if (na == 0) u_sewrp_host.xbits(8'h11, 8, q);
		u_sewrp_host.xbits(8'h80, 1, q);
		u_sewrp_host.desel();
	endtask

	//----------------------------
	// sequence
	//----------------------------
	initial begin
		nrst = 1'b0;
		wp_n = 1'b1;
		repeat (16) @(posedge ref_clk);
		#1 nrst = 1'b1;
		repeat (8) @(posedge ref_clk);
		`CHK(status, 8'h00)
		`CHK(so_oe_n, 1'b1)
		cmd(OPC_STORE, 8'hf4, 8);
		`CHK(status, 8'h00)
		// old bits stand while busy; written ones in b6..4, b1, b0 vanish
		cmd(OPC_ARM, 8'h00, 0);
		cmd(OPC_STORE, 8'hf7, 8);
		`CHK(status, 8'h03)
		idle();
		`CHK(status, 8'h84)
		wr(16'h6000, '{8'h12});
		`CHK(status, 8'h86)
		wr(16'h9ffe, '{8'ha1, 8'ha2, 8'ha3});
		`CHK(status[0], 1'b1)
		hdr(OPC_READ, 16'h1ffe);
		u_sewrp_host.xbits(8'h00, 8, q);
		u_sewrp_host.desel();
		`CHK(drv, 1'b0)
		idle();
		`CHK(status, 8'h84)
		rd(16'h1ffe, '{8'ha1, 8'ha2, 8'hff});
		rd(16'h9fc0, '{8'ha3, 8'hff});
		wr(16'h0000, '{8'h5a});
		idle();
		rd(16'h7fff, '{8'hff, 8'h5a});
		cmd(OPC_ARM, 8'h00, 0);
		odd(OPC_WRITE, 0);
		`CHK(status, 8'h86)
		rd(16'h0100, '{8'hff});
		odd(OPC_STORE, 1);
		`CHK(status, 8'h86)
		// lock set first, pin low last
		setwp(1'b0);
		`CHK(hw_lock, 1'b1)
		cmd(OPC_STORE, 8'h00, 8);
		`CHK(status, 8'h86)
		wr(16'h1000, '{8'h33});
		idle();
		rd(16'h1000, '{8'h33});
		setwp(1'b1);
		`CHK(hw_lock, 1'b0)
		cmd(OPC_ARM, 8'h00, 0);
		cmd(OPC_STORE, 8'h00, 8);
		idle();
		`CHK(status, 8'h00)
		// pin low first, lock set last
		setwp(1'b0);
		`CHK(hw_lock, 1'b0)
		cmd(OPC_ARM, 8'h00, 0);
		cmd(OPC_STORE, 8'h80, 8);
		idle();
		`CHK(status, 8'h80)
		`CHK(hw_lock, 1'b1)
		hdr(OPC_READ, 16'h0000);
		u_sewrp_host.xbits(8'h00, 3, q);
		u_sewrp_host.desel();
		`CHK(drv, 1'b1)
		`CHK(so_oe_n, 1'b1)
		hdr(8'hff, 16'h0000);
		u_sewrp_host.desel();
		`CHK(drv, 1'b0)
		`CHK(status, 8'h80)
		conclude();
	end

endmodule // sewrp_top_test
